// file: verif/dctu_pins_model.sv
// Far-side model: count and reset pins plus a conversion trigger tally
module dctu_pins_model (
  // Clock and pin periods, zero leaves a pin low
  input wire logic i_ref_clk,
  input wire logic [31:0] i_cnt_per,
  input wire logic [31:0] i_rst_per,
  input wire logic [3:0] i_adc_trig,
  // Pins and tally
  output logic [3:0] o_count_pin = '0,
  output logic [3:0] o_reset_pin = '0,
  output int o_adc_seen = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  int t = 0;
  // High for three cycles so the two-stage synchroniser cannot miss a pulse
  always @(posedge i_ref_clk) begin
    t <= t + 1;
    o_count_pin <= #1 {4{i_cnt_per != 0 && t % i_cnt_per < 3}};
    o_reset_pin <= #1 {4{i_rst_per != 0 && t % i_rst_per < 3}};
    o_adc_seen <= o_adc_seen + int'(i_adc_trig[0]);
  end
endmodule

// file: verif/dctu_timer_assertions.sv
// Port-level assertions for the eight-channel timer
module dctu_timer_assertions (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // Configuration
  input wire dctu_pkg::dctu_ch_cfg_t [dctu_pkg::NUM_CH-1:0] i_ch_cfg,
  input wire logic [dctu_pkg::NUM_UNITS-1:0][1:0] i_cas_mode,
  input wire logic [dctu_pkg::NUM_UNITS-1:0] i_module_stop,
  input wire logic [dctu_pkg::NUM_CH-1:0] i_counter_start_register,
  // Observed outputs
  input wire logic [dctu_pkg::NUM_CH-1:0][7:0] o_count,
  input wire dctu_pkg::dctu_evt_t [dctu_pkg::NUM_CH-1:0] o_irq,
  input wire logic [dctu_pkg::NUM_CH-1:0] o_xfer_trig_a,
  input wire logic [dctu_pkg::NUM_CH-1:0] o_xfer_trig_b,
  input wire dctu_pkg::dctu_evt_t [dctu_pkg::NUM_LINK_CH-1:0] o_link,
  input wire logic [dctu_pkg::NUM_UNITS-1:0] o_adc_trig
);
  timeunit 1ns;
  timeprecision 1ps;
  import dctu_pkg::*;
  logic [NUM_CH-1:0] irq_a;
  logic [NUM_CH-1:0] irq_b;
  logic [1:0] up_cnt;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // ==========================================================================
  // Helpers
  // Flatten match A and match B requests so whole vectors compare at once
  always_comb begin
    for (int k = 0; k < NUM_CH; k++) begin
      irq_a[k] = o_irq[k].cmp_a;
      irq_b[k] = o_irq[k].cmp_b;
    end
  end
  // Edges since release, so the prescaler start-up is never judged
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      up_cnt <= 2'h0;
    end else if (up_cnt != 2'h3) begin
      up_cnt <= up_cnt + 2'h1;
    end
  end
  // ==========================================================================
  // Properties
  chk_xfer_a_copy: assert property (o_xfer_trig_a == irq_a)
    else $error("transfer trigger differs from match A");
  chk_xfer_b_copy: assert property (o_xfer_trig_b == irq_b)
    else $error("transfer trigger differs from match B");
  chk_link_out_copy: assert property (o_link == o_irq[NUM_LINK_CH-1:0])
    else $error("link output differs from request");
  chk_adc_even_a: assert property (
    o_adc_trig == {irq_a[6], irq_a[4], irq_a[2], irq_a[0]})
    else $error("conversion trigger not from even match A");
  chk_ovf_after_wrap: assert property (
    o_irq[4].ovf |-> o_count[4] == CNT_RST ##1 !o_irq[4].ovf)
    else $error("overflow without wrap");
  chk_stop_freeze: assert property (
    $past(i_module_stop[3]) |-> $stable(o_count[6]) && $stable(o_count[7]))
    else $error("stopped unit moved");
  chk_start_hold: assert property ($past(!i_counter_start_register[4]
    && i_cas_mode[2] == CAS_8BIT && i_ch_cfg[4].clr_sel != CLR_EXT) |-> $stable(o_count[4]))
    else $error("counter moved without start");
  chk_count_step: assert property (up_cnt == 2'h3 && $past(i_counter_start_register[4]
    && !i_module_stop[2] && i_cas_mode[2] == CAS_8BIT && i_ch_cfg[4].clr_sel == CLR_NONE
    && i_ch_cfg[4].clk_sel == 3'h0) |-> o_count[4] == $past(o_count[4]) + 8'h01)
    else $error("undivided count did not step by one");
  chk_cm_count: assert property ($past(i_cas_mode[2] == CAS_CMCOUNT
    && i_counter_start_register[5] && !i_module_stop[2] && i_ch_cfg[5].clr_sel == CLR_NONE)
    && (o_irq[4].cmp_a || o_irq[4].cmp_b) |-> o_count[5] == $past(o_count[5]) + 8'h01)
    else $error("odd channel missed an even match");
endmodule

// file: verif/dctu_timer_test.sv
// Self-checking bench for the eight-channel timer
module dctu_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dctu_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  dctu_ch_cfg_t [7:0] cfg = '0;
  logic [3:0][1:0] cas = '0;
  logic [3:0] stp = '0;
  logic [7:0] run = '1;
  logic [3:0] lev = '0;
  logic [31:0] cper = 32'd10;
  logic [31:0] rper = '0;
  logic [3:0] cpin, rpin, adc, baud, pbaud;
  logic [7:0] wave, pwave;
  logic [7:0][7:0] cnt, pcnt;
  dctu_evt_t [7:0] irq;
  logic [43:0] ev;
  logic [15:0] c16_prev;
  int fail_count = 0;
  int num_checks = 0;
  int t, adc_n, hi, pwm, c16, ca, cb, d, v0, v1;
  int ev_last[44], ev_exp[44], ev_n[44];
  // Tick spacing per source select, the pin period last
  const int DIVS[8] = '{1, 2, 8, 32, 64, 1024, 8192, 10};
  always #12.5 clk = ~clk;
  dctu_timer i_dut (.i_ref_clk(clk), .i_resetn(rstn), .i_ch_cfg(cfg), .i_cas_mode(cas),
    .i_module_stop(stp), .i_counter_start_register(run), .i_link_event(lev),
    .i_count_pin(cpin), .i_reset_pin(rpin), .o_count(cnt), .o_timer_out(wave), .o_irq(irq),
    .o_xfer_trig_a(), .o_xfer_trig_b(), .o_link(), .o_adc_trig(adc), .o_baud_clk(baud));
  dctu_pins_model i_pins (.i_ref_clk(clk), .i_cnt_per(cper), .i_rst_per(rper),
    .i_adc_trig(adc), .o_count_pin(cpin), .o_reset_pin(rpin), .o_adc_seen(adc_n));
  // ==========================================================================
  // Helpers
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Old settings may still finish a period, so trackers ignore the first cycles
  task automatic go();
    ev_exp = '{default: 0};
    c16 = 0;
    pwm = 0;
    cyc(3);
    ev_last = '{default: -1};
  endtask
  // Model: each source must fire at its exact spacing, or never when quiet
  always @(posedge clk) begin
    #2;
    t++;
    for (int k = 0; k < 8; k++) begin
      ev[4*k+:4] = {irq[k].ovf, irq[k].cmp_b, irq[k].cmp_a, cnt[k] !== pcnt[k]};
      ev[36+k] = wave[k] !== pwave[k];
    end
    ev[35:32] = baud ^ pbaud;
    for (int i = 0; i < 44; i++) begin
      if (ev[i] === 1'b1) begin
        ev_n[i]++;
        if (ev_exp[i] < 0) chk("quiet_source", 0, i + 1);
        else if (ev_exp[i] > 0 && ev_last[i] >= 0) chk("spacing", ev_exp[i], t - ev_last[i]);
        ev_last[i] = t;
      end
    end
    if (c16 > 0) chk("count16", 16'(c16_prev + 16'h1), {cnt[2], cnt[3]});
    c16_prev = {cnt[2], cnt[3]};
    if (wave[6]) hi++;
    else if (hi > 0) begin
      if (pwm > 1) chk("pwm_high", 40 - d, hi);
      pwm += int'(pwm > 0);
      hi = 0;
    end
    pcnt = cnt;
    pwave = wave;
    pbaud = baud;
  end
  // ==========================================================================
  // Tests
  initial begin
    void'($urandom(19813));
    for (int k = 0; k < 8; k++) cfg[k].clk_sel = 3'(k + 4);
    cyc(16);
    rstn = 1'b1;
    go();
    for (int k = 0; k < 8; k++) ev_exp[4*k] = DIVS[(k + 4) % 8];
    ev_exp[19] = 256;
    cyc(16500);
    $display("test ratios done");
    ca = 3 + $urandom % 90;
    cb = 3 + $urandom % 90;
    d = 5 + $urandom % 30;
    cper = '0;
    rper = 32'd50;
    cfg = '0;
    cas = {CAS_8BIT, CAS_CMCOUNT, CAS_16BIT, CAS_8BIT};
    cfg[0] = '{3'h0, CLR_A, ACT_TOGGLE, ACT_KEEP, LINK_NONE, 8'(ca), 8'h00};
    cfg[1] = '{3'h0, CLR_A, ACT_KEEP, ACT_KEEP, LINK_NONE, 8'(cb), 8'h00};
    cfg[4] = '{3'h0, CLR_B, ACT_KEEP, ACT_KEEP, LINK_NONE, 8'hff, 8'h09};
    cfg[6] = '{3'h0, CLR_A, ACT_LOW, ACT_HIGH, LINK_NONE, 8'd40, 8'(d)};
    cfg[7].clr_sel = CLR_EXT;
    go();
    ev_exp[1] = ca + 1;
    ev_exp[36] = ca + 1;
    ev_exp[32] = cb + 1;
    ev_exp[18] = 10;
    ev_exp[20] = 10;
    ev_exp[25] = 41;
    ev_exp[3] = -1;
    ev_exp[15] = -1;
    ev_exp[31] = -1;
    c16 = 1;
    pwm = 1;
    cyc(600);
    chk("adc_count", ev_n[1], adc_n);
    $display("test matches done");
    rper = '0;
    cas = '0;
    stp = 4'h8;
    run = 8'hee;
    cfg[0] = '{3'h0, CLR_NONE, ACT_KEEP, ACT_KEEP, LINK_START, 8'h00, 8'h00};
    cfg[1] = '{CLK_EXT, CLR_NONE, ACT_KEEP, ACT_KEEP, LINK_COUNT, 8'h00, 8'h00};
    cfg[3].link_act = LINK_RESTART;
    go();
    ev_exp[0] = -1;
    ev_exp[4] = -1;
    ev_exp[16] = -1;
    ev_exp[24] = -1;
    ev_exp[28] = -1;
    cyc(20);
    ev_exp[0] = 0;
    ev_exp[4] = 0;
    v0 = cnt[0];
    v1 = cnt[1];
    lev = 4'hb;
    cyc(1);
    lev = '0;
    cyc(3);
    chk("link_count", 8'(v1 + 1), cnt[1]);
    chk("link_start", 1, 8'(cnt[0] - v0) inside {[2:4]});
    chk("link_restart", 1, cnt[3] <= 8'h04);
    $display("test stop and link done");
    end_sim();
  end
  // Watchdog sized well beyond the planned run
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    $display("watchdog expired");
    end_sim();
  end
endmodule
bind dctu_timer dctu_timer_assertions i_chk (.i_ref_clk, .i_resetn, .i_ch_cfg, .i_cas_mode,
  .i_module_stop, .i_counter_start_register, .o_count, .o_irq, .o_xfer_trig_a,
  .o_xfer_trig_b, .o_link, .o_adc_trig);

// file: verilog/dctu_channel.sv
// One 8-bit count channel with clear and waveform output
module dctu_channel (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // Count control
  input wire logic i_tick,
  input wire logic i_clear,
  input wire logic i_match_a,
  input wire logic i_match_b,
  input wire logic [1:0] i_act_a,
  input wire logic [1:0] i_act_b,
  // State
  output logic [7:0] o_count,
  output logic o_wrap,
  output logic o_wave
);
  import dctu_pkg::*;

  logic [7:0] next_count;
  logic next_wave;

  // ==========================================================================
  // Clear wins over counting, so a match clear never also wraps
  always_comb begin
    next_count = o_count;
    if (i_clear) begin
      next_count = CNT_RST;
    end else if (i_tick) begin
      next_count = o_count + 8'h01;
    end
    o_wrap = i_tick && !i_clear && (o_count == CNT_MAX);
  end

  // Waveform: B applied after A, so a set or clear by B wins when both match
  always_comb begin
    next_wave = o_wave;
    if (i_match_a) begin
      case (i_act_a)
        ACT_LOW: next_wave = 1'b0;
        ACT_HIGH: next_wave = 1'b1;
        ACT_TOGGLE: next_wave = !o_wave;
        default: next_wave = o_wave;
      endcase
    end
    if (i_match_b) begin
      case (i_act_b)
        ACT_LOW: next_wave = 1'b0;
        ACT_HIGH: next_wave = 1'b1;
        ACT_TOGGLE: next_wave = !next_wave;
        default: next_wave = next_wave;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_count <= CNT_RST;
      o_wave <= WAVE_RST;
    end else begin
      o_count <= next_count;
      o_wave <= next_wave;
    end
  end

endmodule

// file: verilog/dctu_pkg.sv
// Shared constants and carrier types for the dual channel 8-bit timer unit
package dctu_pkg;

  // ==========================================================================
  // Structure
  localparam int NUM_UNITS = 4;
  localparam int NUM_CH = 8;
  localparam int NUM_LINK_CH = 4;
  localparam int NUM_DIV = 7;
  localparam int PRE_W = 13;

  // ==========================================================================
  // Reset values and limits
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [PRE_W-1:0] PRE_RST = 13'h0000;
  localparam logic WAVE_RST = 1'b0;
  localparam logic BAUD_RST = 1'b0;

  // ==========================================================================
  // Prescaler masks: a tick fires when all masked bits are one
  // Ratios 1, 2, 8, 32, 64, 1024, 8192
  localparam logic [PRE_W-1:0] DIV_MASK [NUM_DIV] = '{
    13'h0000, 13'h0001, 13'h0007, 13'h001f, 13'h003f, 13'h03ff, 13'h1fff
  };

  // ==========================================================================
  // Count source select (0..6 pick a prescaler ratio)
  localparam logic [2:0] CLK_EXT = 3'h7;

  // Counter clear source
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_A = 2'h1;
  localparam logic [1:0] CLR_B = 2'h2;
  localparam logic [1:0] CLR_EXT = 2'h3;

  // Output action on a compare match
  localparam logic [1:0] ACT_KEEP = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // Action on a received link event
  localparam logic [1:0] LINK_NONE = 2'h0;
  localparam logic [1:0] LINK_START = 2'h1;
  localparam logic [1:0] LINK_COUNT = 2'h2;
  localparam logic [1:0] LINK_RESTART = 2'h3;

  // Pairing mode of a unit
  localparam logic [1:0] CAS_8BIT = 2'h0;
  localparam logic [1:0] CAS_16BIT = 2'h1;
  localparam logic [1:0] CAS_CMCOUNT = 2'h2;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [2:0] clk_sel;
    logic [1:0] clr_sel;
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic [1:0] link_act;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
  } dctu_ch_cfg_t;

  typedef struct packed {
    logic cmp_a;
    logic cmp_b;
    logic ovf;
  } dctu_evt_t;

endpackage

// file: verilog/dctu_prescaler.sv
// Free-running prescaler giving one-cycle count enables for each ratio
module dctu_prescaler (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // Enables, one per ratio
  output logic [dctu_pkg::NUM_DIV-1:0] o_tick
);
  import dctu_pkg::*;

  logic [PRE_W-1:0] pre;
  logic [PRE_W-1:0] next_pre;

  // ==========================================================================
  // Counter, shared by every channel so all ratios stay phase aligned
  always_comb begin
    next_pre = pre + 13'h0001;
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pre <= PRE_RST;
    end else begin
      pre <= next_pre;
    end
  end

  // Ratio enables
  always_comb begin
    for (int k = 0; k < NUM_DIV; k++) begin
      o_tick[k] = ((pre & DIV_MASK[k]) == DIV_MASK[k]);
    end
  end

endmodule

// file: verilog/dctu_timer.sv
// Top of the four-unit, eight-channel 8-bit timer
module dctu_timer (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // Configuration
  input wire dctu_pkg::dctu_ch_cfg_t [dctu_pkg::NUM_CH-1:0] i_ch_cfg,
  input wire logic [dctu_pkg::NUM_UNITS-1:0][1:0] i_cas_mode,
  input wire logic [dctu_pkg::NUM_UNITS-1:0] i_module_stop,
  input wire logic [dctu_pkg::NUM_CH-1:0] i_counter_start_register,
  // Link event inputs, same clock domain
  input wire logic [dctu_pkg::NUM_LINK_CH-1:0] i_link_event,
  // Pins, asynchronous
  input wire logic [dctu_pkg::NUM_UNITS-1:0] i_count_pin,
  input wire logic [dctu_pkg::NUM_UNITS-1:0] i_reset_pin,
  // Channel state
  output logic [dctu_pkg::NUM_CH-1:0][7:0] o_count,
  output logic [dctu_pkg::NUM_CH-1:0] o_timer_out,
  // Requests and triggers
  output dctu_pkg::dctu_evt_t [dctu_pkg::NUM_CH-1:0] o_irq,
  output logic [dctu_pkg::NUM_CH-1:0] o_xfer_trig_a,
  output logic [dctu_pkg::NUM_CH-1:0] o_xfer_trig_b,
  output dctu_pkg::dctu_evt_t [dctu_pkg::NUM_LINK_CH-1:0] o_link,
  output logic [dctu_pkg::NUM_UNITS-1:0] o_adc_trig,
  output logic [dctu_pkg::NUM_UNITS-1:0] o_baud_clk
);
  import dctu_pkg::*;

  // ==========================================================================
  // Declarations
  logic [NUM_DIV-1:0] div_tick;
  logic [NUM_UNITS-1:0] cnt_s1, cnt_s2, cnt_s3;
  logic [NUM_UNITS-1:0] rst_s1, rst_s2, rst_s3;
  logic [NUM_UNITS-1:0] cnt_edge, rst_edge;
  logic [NUM_LINK_CH-1:0] link_run, next_link_run;
  logic [NUM_CH-1:0] run, base, tick, eq_a, eq_b, m_a, m_b, clr, wrap, ovf;
  dctu_evt_t [NUM_CH-1:0] next_irq;
  logic [NUM_CH-1:0] next_xfer_a, next_xfer_b;
  dctu_evt_t [NUM_LINK_CH-1:0] next_link;
  logic [NUM_UNITS-1:0] next_adc, next_baud;

  // ==========================================================================
  // Prescaler
  dctu_prescaler u_pre (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .o_tick(div_tick)
  );

  // ==========================================================================
  // Pin synchronisers: stage one feeds only stage two
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_s1 <= '0;
      cnt_s2 <= '0;
      cnt_s3 <= '0;
      rst_s1 <= '0;
      rst_s2 <= '0;
      rst_s3 <= '0;
    end else begin
      cnt_s1 <= i_count_pin;
      cnt_s2 <= cnt_s1;
      cnt_s3 <= cnt_s2;
      rst_s1 <= i_reset_pin;
      rst_s2 <= rst_s1;
      rst_s3 <= rst_s2;
    end
  end

  // Rising edges only; a held pin counts or clears once
  assign cnt_edge = cnt_s2 & ~cnt_s3;
  assign rst_edge = rst_s2 & ~rst_s3;

  // ==========================================================================
  // Per-channel run gate and count source
  always_comb begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      run[ch] = i_counter_start_register[ch] && !i_module_stop[ch/2];
      if (ch < NUM_LINK_CH) begin
        run[ch] = (i_counter_start_register[ch] || link_run[ch])
          && !i_module_stop[ch/2];
      end
      if (i_ch_cfg[ch].clk_sel == CLK_EXT) begin
        base[ch] = run[ch] && cnt_edge[ch/2];
      end else begin
        base[ch] = run[ch] && div_tick[i_ch_cfg[ch].clk_sel];
      end
      if (ch < NUM_LINK_CH && i_ch_cfg[ch].link_act == LINK_COUNT) begin
        base[ch] = run[ch] && i_link_event[ch];
      end
      eq_a[ch] = (o_count[ch] == i_ch_cfg[ch].cmp_a);
      eq_b[ch] = (o_count[ch] == i_ch_cfg[ch].cmp_b);
    end
  end

  // ==========================================================================
  // Unit pairing: ticks, matches, clears, reported overflow
  // Matches fire on the tick that leaves the compare value, so a match
  // clear gives a period of compare value plus one
  always_comb begin
    tick = '0;
    m_a = '0;
    m_b = '0;
    clr = '0;
    ovf = '0;
    for (int u = 0; u < NUM_UNITS; u++) begin
      tick[2*u] = base[2*u];
      tick[2*u+1] = base[2*u+1];
      if (i_cas_mode[u] == CAS_16BIT) begin
        // Upper half steps on lower wrap, so one prescaler drives both
        tick[2*u] = wrap[2*u+1] && !i_module_stop[u];
        m_a[2*u] = tick[2*u+1] && eq_a[2*u] && eq_a[2*u+1];
        m_b[2*u] = tick[2*u+1] && eq_b[2*u] && eq_b[2*u+1];
        m_a[2*u+1] = m_a[2*u];
        m_b[2*u+1] = m_b[2*u];
      end else begin
        m_a[2*u] = tick[2*u] && eq_a[2*u];
        m_b[2*u] = tick[2*u] && eq_b[2*u];
        if (i_cas_mode[u] == CAS_CMCOUNT) begin
          tick[2*u+1] = run[2*u+1] && (m_a[2*u] || m_b[2*u]);
        end
        m_a[2*u+1] = tick[2*u+1] && eq_a[2*u+1];
        m_b[2*u+1] = tick[2*u+1] && eq_b[2*u+1];
      end
      for (int k = 0; k < 2; k++) begin
        logic [1:0] sel;
        sel = i_ch_cfg[2*u+k].clr_sel;
        if (i_cas_mode[u] == CAS_16BIT) begin
          sel = i_ch_cfg[2*u].clr_sel; // Pair clears as one counter
        end
        clr[2*u+k] = (sel == CLR_A && m_a[2*u+k])
          || (sel == CLR_B && m_b[2*u+k])
          || (sel == CLR_EXT && rst_edge[u] && !i_module_stop[u]);
      end
      ovf[2*u] = wrap[2*u];
      ovf[2*u+1] = wrap[2*u+1] && (i_cas_mode[u] != CAS_16BIT);
    end
    // Restart clears the counter as the run flag is raised
    for (int ch = 0; ch < NUM_LINK_CH; ch++) begin
      if (i_ch_cfg[ch].link_act == LINK_RESTART && i_link_event[ch]
          && !i_module_stop[ch/2]) begin
        clr[ch] = 1'b1;
      end
    end
  end

  // ==========================================================================
  // Channels
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    dctu_channel u_ch (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_tick(tick[g]),
      .i_clear(clr[g]),
      .i_match_a(m_a[g]),
      .i_match_b(m_b[g]),
      .i_act_a(i_ch_cfg[g].act_a),
      .i_act_b(i_ch_cfg[g].act_b),
      .o_count(o_count[g]),
      .o_wrap(wrap[g]),
      .o_wave(o_timer_out[g])
    );
  end

  // ==========================================================================
  // Link run flags: set by start or restart, held until reset or link action none
  // Software stops a link-started channel by setting its link action to none
  always_comb begin
    next_link_run = link_run;
    for (int ch = 0; ch < NUM_LINK_CH; ch++) begin
      if (i_link_event[ch] && !i_module_stop[ch/2]
          && (i_ch_cfg[ch].link_act == LINK_START
          || i_ch_cfg[ch].link_act == LINK_RESTART)) begin
        next_link_run[ch] = 1'b1;
      end
      if (i_ch_cfg[ch].link_act == LINK_NONE) begin
        next_link_run[ch] = 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      link_run <= '0;
    end else begin
      link_run <= next_link_run;
    end
  end

  // ==========================================================================
  // Event outputs, registered so every pulse is one clean cycle
  always_comb begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      next_irq[ch].cmp_a = m_a[ch];
      next_irq[ch].cmp_b = m_b[ch];
      next_irq[ch].ovf = ovf[ch];
      next_xfer_a[ch] = m_a[ch];
      next_xfer_b[ch] = m_b[ch];
    end
    for (int ch = 0; ch < NUM_LINK_CH; ch++) begin
      next_link[ch].cmp_a = m_a[ch];
      next_link[ch].cmp_b = m_b[ch];
      next_link[ch].ovf = ovf[ch];
    end
    for (int u = 0; u < NUM_UNITS; u++) begin
      next_adc[u] = m_a[2*u];
      // Baud clock halves the odd channel match A rate
      next_baud[u] = o_baud_clk[u] ^ m_a[2*u+1];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq <= '0;
      o_xfer_trig_a <= '0;
      o_xfer_trig_b <= '0;
      o_link <= '0;
      o_adc_trig <= '0;
      o_baud_clk <= {NUM_UNITS{BAUD_RST}};
    end else begin
      o_irq <= next_irq;
      o_xfer_trig_a <= next_xfer_a;
      o_xfer_trig_b <= next_xfer_b;
      o_link <= next_link;
      o_adc_trig <= next_adc;
      o_baud_clk <= next_baud;
    end
  end

endmodule
